// [dv/encoder_position_timer_regs_tb_top.sv]
// Top testbench of the position timer block
`timescale 1ns/1ps
`default_nettype none
module encoder_position_timer_regs_tb_top;
    typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] x;} ept_row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, lval = 32'h0000_0000, prdata, pos, q;
    logic pready, pslverr, qclk, ipin, spin, sync_out, irq, e;
    logic idx = 1'b0, stb = 1'b0, mv = 1'b0, ld = 1'b0;
    int n_errors = 0, checks = 0, cyc = 0, syncs = 0;
    ept_row_s rows [9] = '{
        '{12'h020, 32'hffff_ffff, 32'hffff_ffff},
        '{12'h030, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
        '{12'h040, 32'h1234_5678, 32'h0000_0000},
        '{12'h050, 32'h1234_5678, 32'h0000_0000},
        '{12'h060, 32'h1234_5678, 32'h0000_0000},
        '{12'h070, 32'h0000_0100, 32'h0000_0100},
        '{12'h080, 32'hdead_beef, 32'hdead_beef},
        '{12'h090, 32'hffff_1234, 32'h0000_1234},
        '{12'h098, 32'hffff_abcd, 32'h0000_abcd}};

    always #10 pclk = ~pclk;

    ept_position_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .position_counter(pos), .qclk(qclk), .index_pin(ipin),
        .strobe_pin(spin), .sync_out(sync_out), .irq(irq));
    ept_encoder_model enc (.pclk(pclk), .moving(mv), .load_en(ld), .load_val(lval),
        .index_lvl(idx), .strobe_lvl(stb), .position_counter(pos), .qclk(qclk),
        .index_pin(ipin), .strobe_pin(spin));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x)
        begin
            n_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, g, x);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic ld_pos(input logic [31:0] v);
        @(posedge pclk);
        lval <= v;
        ld <= 1'b1;
        @(posedge pclk);
        ld <= 1'b0;
    endtask : ld_pos

    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    always @(posedge pclk)
    begin
        cyc++;
        if (sync_out === 1'b1)
            syncs++;
        if (cyc == 20000)
        begin
            n_errors++;
            close_out();
        end
    end

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            xfer(1'b0, rows[i].a, 32'h0000_0000);
            chk(q, 32'h0000_0000);
        end
        foreach (rows[i])
        begin
            xfer(1'b1, rows[i].a, rows[i].w);
            xfer(1'b0, rows[i].a, 32'h0000_0000);
            chk(q, rows[i].x);
        end
        xfer(1'b0, 12'h022, 32'h0000_0000);
        chk({31'h0000_0000, e}, 32'h0000_0001);
        xfer(1'b0, 12'h004, 32'h0000_0000);
        chk({q[30:0], e}, 32'h0000_0001);
        // Index modes off, rising, falling, both; strobe rising or both
        for (int m = 0; m < 4; m++)
        begin
            xfer(1'b1, 12'h0a0, 32'((m << 2) | ((m & 1) << 4)));
            ld_pos(32'h0000_0100 + 32'(m));
            idx <= 1'b1;
            stb <= 1'b1;
            repeat (8) @(posedge pclk);
            ld_pos(32'h0000_0200 + 32'(m));
            idx <= 1'b0;
            stb <= 1'b0;
            repeat (8) @(posedge pclk);
            xfer(1'b0, 12'h040, 32'h0000_0000);
            chk(q, m == 0 ? 32'h0 : (m == 1 ? 32'h100 + 32'(m) : 32'h200 + 32'(m)));
            xfer(1'b0, 12'h050, 32'h0000_0000);
            chk(q, (m & 1) ? 32'h200 + 32'(m) : 32'h100 + 32'(m));
            xfer(1'b0, 12'h0a4, 32'h0000_0000);
            chk(q & 32'h0000_0006, m == 0 ? 32'h0000_0004 : 32'h0000_0006);
            xfer(1'b1, 12'h0a4, 32'h0000_0006);
        end
        xfer(1'b1, 12'h0a4, 32'h0000_001f);
        xfer(1'b1, 12'h0a8, 32'h0000_0008);
        xfer(1'b1, 12'h070, 32'h0000_0000);
        xfer(1'b1, 12'h080, 32'h0000_0028);
        xfer(1'b1, 12'h0a0, 32'h0000_0002);
        repeat (30) @(posedge pclk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        repeat (20) @(posedge pclk);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        xfer(1'b0, 12'h060, 32'h0000_0000);
        chk(q, 32'h0000_0203);
        xfer(1'b0, 12'h070, 32'h0000_0000);
        chk({31'h0000_0000, q < 32'h0000_0029}, 32'h0000_0001);
        xfer(1'b1, 12'h0a4, 32'h0000_0008);
        repeat (2) @(posedge pclk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        xfer(1'b1, 12'h0a8, 32'h0000_0000);
        repeat (60) @(posedge pclk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        xfer(1'b0, 12'h0a4, 32'h0000_0000);
        chk(q & 32'h0000_0008, 32'h0000_0008);
        // Stall watchdog with period 2: motion holds it off, a stop trips it
        xfer(1'b1, 12'h0a0, 32'h0000_0001);
        xfer(1'b1, 12'h098, 32'h0000_0002);
        xfer(1'b1, 12'h090, 32'h0000_0000);
        xfer(1'b1, 12'h0a4, 32'h0000_001f);
        xfer(1'b1, 12'h0a8, 32'h0000_0010);
        mv <= 1'b1;
        repeat (400) @(posedge pclk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        mv <= 1'b0;
        repeat (120) @(posedge pclk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        repeat (150) @(posedge pclk);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        // Compare passed once while moving
        ld_pos(32'h0000_0500);
        xfer(1'b1, 12'h030, 32'h0000_0505);
        xfer(1'b1, 12'h0a0, 32'h0000_0060);
        xfer(1'b1, 12'h0a4, 32'h0000_001f);
        xfer(1'b1, 12'h0a8, 32'h0000_0001);
        syncs = 0;
        mv <= 1'b1;
        repeat (40) @(posedge pclk);
        mv <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(32'(syncs), 32'h0000_0001);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        // Reset in mid-run returns the nine table registers and the interrupt to zero
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            xfer(1'b0, rows[i].a, 32'h0000_0000);
            chk(q, 32'h0000_0000);
        end
        close_out();
    end
endmodule : encoder_position_timer_regs_tb_top

bind ept_position_timer ept_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_out(sync_out));
`default_nettype wire

// [dv/ept_encoder_model.sv]
// Encoder model: position count, quadrature clock, index and strobe pins
`timescale 1ns/1ps
`default_nettype none
module ept_encoder_model (
    // Clock
    input wire logic pclk,
    // Bench controls
    input wire logic moving,
    input wire logic load_en,
    input wire logic [31:0] load_val,
    input wire logic index_lvl,
    input wire logic strobe_lvl,
    // Encoder side
    output logic [31:0] position_counter,
    output logic qclk,
    output logic index_pin,
    output logic strobe_pin
);
    logic [1:0] div;

    initial
    begin
        div = 2'h0;
        qclk = 1'b0;
        position_counter = 32'h0000_0000;
    end

    // One quadrature edge and one count every fourth cycle while moving
    always @(posedge pclk)
    begin
        div <= div + 2'h1;
        if (load_en)
            position_counter <= load_val;
        else if (moving && div == 2'h3)
        begin
            qclk <= !qclk;
            position_counter <= position_counter + 32'h0000_0001;
        end
    end

    assign index_pin = index_lvl;
    assign strobe_pin = strobe_lvl;
endmodule : ept_encoder_model
`default_nettype wire

// [dv/ept_monitor.sv]
// Checker of the APB port and sync output of the position timer block
`timescale 1ns/1ps
`default_nettype none
module ept_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Outputs
    input wire logic sync_out
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence

    sequence rd_s(logic [11:0] a);
        setup_s ##0 (!pwrite && paddr == a);
    endsequence

    ready_after_setup_a: assert property (setup_s |=> pready && penable)
        else $error("no ready in the access cycle");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unaligned_error_a: assert property (setup_s ##0 (paddr[1:0] != 2'h0) |=> pslverr)
        else $error("unaligned access not refused");
    max_pos_mapped_a: assert property (rd_s(12'h020) |=> !pslverr)
        else $error("maximum position register refused");
    wd_period_upper_a: assert property (rd_s(12'h098) |=> prdata[31:16] == 16'h0000)
        else $error("watchdog period upper half not zero");
    wd_count_upper_a: assert property (rd_s(12'h090) |=> prdata[31:16] == 16'h0000)
        else $error("watchdog count upper half not zero");
    sync_one_cycle_a: assert property (sync_out |=> !sync_out)
        else $error("sync pulse longer than one cycle");
endmodule : ept_monitor
`default_nettype wire

// [hdl/ept_defs.svh]
// Register map, field positions, reset values and timing counts of the position timer block
`ifndef EPT_DEFS_SVH
`define EPT_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define EPT_IDX_MAX_POS 8'h08
`define EPT_IDX_POS_CMP 8'h0c
`define EPT_IDX_IDX_LAT 8'h10
`define EPT_IDX_STB_LAT 8'h14
`define EPT_IDX_UNIT_LAT 8'h18
`define EPT_IDX_UNIT_TMR 8'h1c
`define EPT_IDX_UNIT_PRD 8'h20
`define EPT_IDX_WD_TMR 8'h24
`define EPT_IDX_WD_PRD 8'h26
`define EPT_IDX_CTRL 8'h28
`define EPT_IDX_FLAGS 8'h29
`define EPT_IDX_MASK 8'h2a

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define EPT_CTRL_WD_EN 0
`define EPT_CTRL_UT_EN 1
`define EPT_CTRL_IDX_SEL_LSB 2
`define EPT_CTRL_SEL 4
`define EPT_CTRL_CMP_EN 5
`define EPT_CTRL_SYNC_EN 6
`define EPT_CTRL_W 7

// ----------------------------------------------------------------
// Flag and mask fields
// ----------------------------------------------------------------
`define EPT_FLG_CMP 0
`define EPT_FLG_IDX 1
`define EPT_FLG_STB 2
`define EPT_FLG_UNIT 3
`define EPT_FLG_WDOG 4
`define EPT_FLG_W 5

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define EPT_RST_32 32'h0000_0000
`define EPT_RST_16 16'h0000
`define EPT_WD_DIV 7'h40

`endif

// [hdl/ept_pkg.sv]
// Types shared by the position timer block
package ept_pkg;

    // Index latch select encodings
    typedef enum logic [1:0] {
        EPT_IDX_LATCH_OFF = 2'h0,
        EPT_IDX_LATCH_RISE = 2'h1,
        EPT_IDX_LATCH_FALL = 2'h2,
        EPT_IDX_LATCH_BOTH = 2'h3
    } ept_idx_latch_e;

endpackage : ept_pkg

// [hdl/ept_position_timer.sv]
// Position compare, position latches, unit timer and stall watchdog with an APB register port
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ept_defs.svh"

module ept_position_timer #(
    parameter int POS_W = 32,
    parameter int WD_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Unit side, same clock
    input wire logic [POS_W-1:0] position_counter,
    input wire logic qclk,
    // Encoder pins, asynchronous
    input wire logic index_pin,
    input wire logic strobe_pin,
    // Outputs
    output logic sync_out,
    output logic irq
);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [POS_W-1:0] max_position_count;
    logic [POS_W-1:0] position_compare_value;
    logic [POS_W-1:0] index_position_latch;
    logic [POS_W-1:0] strobe_position_latch;
    logic [POS_W-1:0] unit_position_latch;
    logic [31:0] unit_timer_count;
    logic [31:0] unit_period_value;
    logic [WD_W-1:0] stall_watchdog_count;
    logic [WD_W-1:0] stall_watchdog_period;
    logic [`EPT_CTRL_W-1:0] ctrl;
    logic [`EPT_FLG_W-1:0] flags;
    logic [`EPT_FLG_W-1:0] mask;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic setup;
    logic wr_fire;
    logic [7:0] idx;
    logic addr_ok;

    function automatic logic hit(input logic [11:0] a, input logic [7:0] i);
        hit = (a[1:0] == 2'h0) && (a[9:2] == i) && (a[11:10] == 2'h0);
    endfunction : hit

    assign setup = psel & ~penable;
    assign wr_fire = psel & penable & pready & pwrite;
    assign idx = paddr[9:2];

    always_comb
    begin
        addr_ok = 1'b0;
        if (paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0)
        begin
            unique case (idx)
                `EPT_IDX_MAX_POS, `EPT_IDX_POS_CMP, `EPT_IDX_IDX_LAT, `EPT_IDX_STB_LAT,
                `EPT_IDX_UNIT_LAT, `EPT_IDX_UNIT_TMR, `EPT_IDX_UNIT_PRD, `EPT_IDX_WD_TMR,
                `EPT_IDX_WD_PRD, `EPT_IDX_CTRL, `EPT_IDX_FLAGS, `EPT_IDX_MASK:
                    addr_ok = 1'b1;
                default:
                    addr_ok = 1'b0;
            endcase
        end
    end

    // Answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup & ~addr_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= `EPT_RST_32;
        else if (setup && !pwrite)
        begin
            prdata <= `EPT_RST_32;
            unique case (1'b1)
                hit(paddr, `EPT_IDX_MAX_POS): prdata <= 32'(max_position_count);
                hit(paddr, `EPT_IDX_POS_CMP): prdata <= 32'(position_compare_value);
                hit(paddr, `EPT_IDX_IDX_LAT): prdata <= 32'(index_position_latch);
                hit(paddr, `EPT_IDX_STB_LAT): prdata <= 32'(strobe_position_latch);
                hit(paddr, `EPT_IDX_UNIT_LAT): prdata <= 32'(unit_position_latch);
                hit(paddr, `EPT_IDX_UNIT_TMR): prdata <= unit_timer_count;
                hit(paddr, `EPT_IDX_UNIT_PRD): prdata <= unit_period_value;
                hit(paddr, `EPT_IDX_WD_TMR): prdata <= 32'(stall_watchdog_count);
                hit(paddr, `EPT_IDX_WD_PRD): prdata <= 32'(stall_watchdog_period);
                hit(paddr, `EPT_IDX_CTRL): prdata <= 32'(ctrl);
                hit(paddr, `EPT_IDX_FLAGS): prdata <= 32'(flags);
                hit(paddr, `EPT_IDX_MASK): prdata <= 32'(mask);
                default: prdata <= `EPT_RST_32;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Plain read/write registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            max_position_count <= POS_W'(`EPT_RST_32);
            position_compare_value <= POS_W'(`EPT_RST_32);
            unit_period_value <= `EPT_RST_32;
            stall_watchdog_period <= WD_W'(`EPT_RST_16);
            ctrl <= '0;
            mask <= '0;
        end
        else if (wr_fire)
        begin
            if (hit(paddr, `EPT_IDX_MAX_POS))
                max_position_count <= pwdata[POS_W-1:0];
            if (hit(paddr, `EPT_IDX_POS_CMP))
                position_compare_value <= pwdata[POS_W-1:0];
            if (hit(paddr, `EPT_IDX_UNIT_PRD))
                unit_period_value <= pwdata;
            if (hit(paddr, `EPT_IDX_WD_PRD))
                stall_watchdog_period <= pwdata[WD_W-1:0];
            if (hit(paddr, `EPT_IDX_CTRL))
                ctrl <= pwdata[`EPT_CTRL_W-1:0];
            if (hit(paddr, `EPT_IDX_MASK))
                mask <= pwdata[`EPT_FLG_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [1:0] pin_raw;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;

    assign pin_raw = {strobe_pin, index_pin};

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_pin
            logic s1;
            logic s2;
            logic s3;
            logic level;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    level <= 1'b0;
                end
                else
                begin
                    s1 <= pin_raw[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                        level <= s3;
                end
            end
            assign pin_rise[g] = (s2 == s3) & s3 & ~level;
            assign pin_fall[g] = (s2 == s3) & ~s3 & level;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Index and strobe latches
    // ----------------------------------------------------------------
    ept_pkg::ept_idx_latch_e index_latch_select;
    logic index_event;
    logic strobe_event;

    assign index_latch_select = ept_pkg::ept_idx_latch_e'(ctrl[`EPT_CTRL_IDX_SEL_LSB +: 2]);

    always_comb
    begin
        unique case (index_latch_select)
            ept_pkg::EPT_IDX_LATCH_OFF: index_event = 1'b0;
            ept_pkg::EPT_IDX_LATCH_RISE: index_event = pin_rise[0];
            ept_pkg::EPT_IDX_LATCH_FALL: index_event = pin_fall[0];
            ept_pkg::EPT_IDX_LATCH_BOTH: index_event = pin_rise[0] | pin_fall[0];
        endcase
    end

    // Strobe select: 0 latches on rising edge, 1 on both edges
    assign strobe_event = pin_rise[1] | (ctrl[`EPT_CTRL_SEL] & pin_fall[1]);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            index_position_latch <= POS_W'(`EPT_RST_32);
        else if (index_event)
            index_position_latch <= position_counter;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            strobe_position_latch <= POS_W'(`EPT_RST_32);
        else if (strobe_event)
            strobe_position_latch <= position_counter;
    end

    // ----------------------------------------------------------------
    // Unit timer
    // ----------------------------------------------------------------
    logic unit_event;

    assign unit_event = ctrl[`EPT_CTRL_UT_EN] && (unit_timer_count == unit_period_value);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            unit_timer_count <= `EPT_RST_32;
        else if (wr_fire && hit(paddr, `EPT_IDX_UNIT_TMR))
            unit_timer_count <= pwdata;
        else if (unit_event)
            unit_timer_count <= `EPT_RST_32;
        else if (ctrl[`EPT_CTRL_UT_EN])
            unit_timer_count <= unit_timer_count + 32'h0000_0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            unit_position_latch <= POS_W'(`EPT_RST_32);
        else if (unit_event)
            unit_position_latch <= position_counter;
    end

    // ----------------------------------------------------------------
    // Stall watchdog
    // ----------------------------------------------------------------
    logic [6:0] wd_div;
    logic wd_tick;
    logic qclk_q;
    logic qclk_edge;
    logic wd_event;

    assign wd_tick = ctrl[`EPT_CTRL_WD_EN] && (wd_div == `EPT_WD_DIV - 7'h01);
    assign qclk_edge = qclk ^ qclk_q;
    assign wd_event = wd_tick && !qclk_edge && (stall_watchdog_count == stall_watchdog_period);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wd_div <= 7'h00;
        else if (!ctrl[`EPT_CTRL_WD_EN] || wd_tick)
            wd_div <= 7'h00;
        else
            wd_div <= wd_div + 7'h01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            qclk_q <= 1'b0;
        else
            qclk_q <= qclk;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stall_watchdog_count <= WD_W'(`EPT_RST_16);
        else if (wr_fire && hit(paddr, `EPT_IDX_WD_TMR))
            stall_watchdog_count <= pwdata[WD_W-1:0];
        else if (qclk_edge)
            stall_watchdog_count <= WD_W'(`EPT_RST_16);
        else if (wd_tick)
            stall_watchdog_count <= stall_watchdog_count + WD_W'(1);
    end

    // ----------------------------------------------------------------
    // Position compare
    // ----------------------------------------------------------------
    logic cmp_eq;
    logic cmp_eq_q;
    logic cmp_event;

    assign cmp_eq = (position_counter == position_compare_value);
    assign cmp_event = ctrl[`EPT_CTRL_CMP_EN] & cmp_eq & ~cmp_eq_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_eq_q <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            cmp_eq_q <= cmp_eq;
            sync_out <= cmp_event & ctrl[`EPT_CTRL_SYNC_EN];
        end
    end

    // ----------------------------------------------------------------
    // Interrupt flags
    // ----------------------------------------------------------------
    logic [`EPT_FLG_W-1:0] flag_set;
    logic [`EPT_FLG_W-1:0] flag_clr;

    always_comb
    begin
        flag_set = '0;
        flag_set[`EPT_FLG_CMP] = cmp_event;
        flag_set[`EPT_FLG_IDX] = index_event;
        flag_set[`EPT_FLG_STB] = strobe_event;
        flag_set[`EPT_FLG_UNIT] = unit_event;
        flag_set[`EPT_FLG_WDOG] = wd_event;
    end

    assign flag_clr = (wr_fire && hit(paddr, `EPT_IDX_FLAGS)) ? pwdata[`EPT_FLG_W-1:0] : '0;

    // A set in the same cycle as its clear wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags <= '0;
        else
            flags <= (flags & ~flag_clr) | flag_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(flags & mask);
    end

endmodule : ept_position_timer
`default_nettype wire
